// ===== dword16_cmd.sv
// Purpose: Parameter dword 16 read-out, soft reset pair, SR1 write arming
// Assumes: Host keeps commands well formed; link clock slower than core/4
// Notes:   Non-volatile copy is a register standing in for the array cell
// Overview of operation
// - Parameter read at bytes 68h..6Bh returns E8h, 30h, C0h, 80h.
// - No 4-byte entry; bits 31:24 read 10000000b.
// - No 4-byte exit; bits 23:14 read 11_0000_0000b.
// - Soft reset happens only on 66h then 99h.
// - Reset pair accepted on 1, 2 or 4 wires, per current mode.
// - Bits 13:8 read 11_0000b; bit 7 reads one.
// - At power-up both SR1 copies load SR1_NV_RESET; soft reset reloads SR1 from the non-volatile copy.
// - 06h arms next status write to update the non-volatile SR1.
// - 50h arms status write affecting only the volatile SR1.
// - Bits 6:0 read 1101000b.
// - Reset takes about 10us; all commands rejected meanwhile.
module dword16_cmd #(
  parameter int RESET_CYCLES = dword16_pkg::RESET_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       clkEn,
  // Link pins
  input  wire logic       sck,
  input  wire logic       csN,
  input  wire logic [3:0] ioIn,
  output logic [3:0]      ioOut,
  output logic [3:0]      ioOe,
  // Operating width: 0 single, 1 dual, 2 quad
  input  wire logic [1:0] laneMode,
  // Status
  output logic [7:0]      sr1Volatile,
  output logic [7:0]      sr1NonVol,
  output logic            resetBusy
);
  // ---------------------------------------------------------------
  // Serial front end
  // ---------------------------------------------------------------
  logic       byteValid;
  logic [7:0] byteData;
  logic       frameStart;
  logic       frameEnd;
  logic       selected;
  logic       sckFall;
  spi_shifter u_shift (
    .core_clk  (core_clk),
    .reset     (reset),
    .clkEn     (clkEn),
    .sck       (sck),
    .csN       (csN),
    .ioIn      (ioIn),
    .laneMode  (laneMode),
    .byteValid (byteValid),
    .byteData  (byteData),
    .frameStart(frameStart),
    .frameEnd  (frameEnd),
    .selected  (selected),
    .sckFall   (sckFall)
  );
  // ---------------------------------------------------------------
  // Frame state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FR_IDLE  = 3'b000,
    FR_CMD   = 3'b001,
    FR_ADDR  = 3'b010,
    FR_DUMMY = 3'b011,
    FR_DATA  = 3'b100,
    FR_WDATA = 3'b101,
    FR_SKIP  = 3'b110
  } frame_e;
  frame_e     frame_q;
  logic [7:0] cmd_q;
  logic [1:0] addrCnt_q;
  logic [7:0] addr_q;
  logic [7:0] wrByte_q;
  logic       wrSeen_q;
  logic       rstArmed_q;
  logic       wenNv_q;
  logic       wenVol_q;
  logic       fire;
  logic       rejecting;
  assign rejecting = resetBusy;
  // Reset fires at frame end so the host finishes its clocks first
  assign fire = frameEnd && frame_q == FR_SKIP && cmd_q == dword16_pkg::CMD_RST
                && rstArmed_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      frame_q   <= FR_IDLE;
      cmd_q     <= 8'h00;
      addrCnt_q <= 2'd0;
      addr_q    <= 8'h00;
      wrByte_q  <= 8'h00;
      wrSeen_q  <= 1'b0;
    end else if (clkEn) begin
      if (frameStart) begin
        frame_q  <= rejecting ? FR_SKIP : FR_CMD;
        cmd_q    <= 8'h00;
        wrSeen_q <= 1'b0;
      end else if (frameEnd) begin
        frame_q <= FR_IDLE;
      end else if (byteValid) begin
        unique case (frame_q)
          FR_CMD: begin
            cmd_q     <= byteData;
            addrCnt_q <= 2'd0;
            if (byteData == dword16_pkg::CMD_PARAM_RD) begin
              frame_q <= FR_ADDR;
            end else if (byteData == dword16_pkg::CMD_WRSR1 ||
                         byteData == dword16_pkg::CMD_WRSR2) begin
              frame_q <= FR_WDATA;
            end else if (byteData == dword16_pkg::CMD_RDSR) begin
              frame_q <= FR_DATA;
            end else begin
              frame_q <= FR_SKIP;
            end
          end
          FR_ADDR: begin
            addr_q    <= byteData;
            addrCnt_q <= addrCnt_q + 2'd1;
            if (addrCnt_q == 2'd2) begin
              frame_q <= FR_DUMMY;
            end
          end
          FR_DUMMY: frame_q <= FR_DATA;
          FR_DATA:  addr_q <= addr_q + 8'h01;
          FR_WDATA: begin
            if (!wrSeen_q) begin
              wrByte_q <= byteData;
              wrSeen_q <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // Soft reset pair and recovery timer
  // ---------------------------------------------------------------
  logic        cmdDone;
  logic [15:0] rstCnt_q;
  assign cmdDone = frameEnd && (frame_q != FR_IDLE) && (frame_q != FR_CMD)
                   && !rejecting;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rstArmed_q <= 1'b0;
    end else if (clkEn && cmdDone) begin
      rstArmed_q <= (cmd_q == dword16_pkg::CMD_RST_EN);
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rstCnt_q  <= 16'h0000;
      resetBusy <= 1'b0;
    end else if (clkEn) begin
      if (fire && !rejecting) begin
        rstCnt_q  <= 16'(RESET_CYCLES);
        resetBusy <= 1'b1;
      end else if (rstCnt_q != 16'h0000) begin
        rstCnt_q <= rstCnt_q - 16'h0001;
        if (rstCnt_q == 16'h0001) begin
          resetBusy <= 1'b0;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // Status register 1 copies and write arming
  // ---------------------------------------------------------------
  logic wrsrDone;
  assign wrsrDone = cmdDone && wrSeen_q && frame_q == FR_WDATA;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wenNv_q  <= 1'b0;
      wenVol_q <= 1'b0;
    end else if (clkEn) begin
      if (fire) begin
        wenNv_q  <= 1'b0;
        wenVol_q <= 1'b0;
      end else if (cmdDone) begin
        wenNv_q  <= (cmd_q == dword16_pkg::CMD_WREN) ||
                    (wenNv_q && cmd_q != dword16_pkg::CMD_WRSR1 &&
                     cmd_q != dword16_pkg::CMD_WRSR2);
        wenVol_q <= (cmd_q == dword16_pkg::CMD_VWREN);
      end
    end
  end
  // Non-volatile copy: a real part keeps it across power loss
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sr1NonVol <= dword16_pkg::SR1_NV_RESET;
    end else if (clkEn && wrsrDone && wenNv_q && !wenVol_q) begin
      sr1NonVol <= wrByte_q;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sr1Volatile <= dword16_pkg::SR1_NV_RESET;
    end else if (clkEn) begin
      if (fire) begin
        sr1Volatile <= sr1NonVol;
      end else if (wrsrDone && (wenVol_q || wenNv_q)) begin
        sr1Volatile <= wrByte_q;
      end
    end
  end
  // ---------------------------------------------------------------
  // Read-out path, single wire on the data-out pin
  // ---------------------------------------------------------------
  logic [7:0] outByte;
  logic [7:0] outShift_q;
  logic [2:0] outBit_q;
  logic [7:0] rel;
  always_comb begin
    rel     = addr_q - dword16_pkg::PARAM_BASE;
    outByte = 8'h00;
    if (cmd_q == dword16_pkg::CMD_RDSR) begin
      outByte = sr1Volatile;
    end else if (rel < 8'h04) begin
      outByte = dword16_pkg::DWORD16[rel[1:0]*8 +: 8];
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      outShift_q <= 8'h00;
      outBit_q   <= 3'd0;
      ioOut      <= 4'h0;
      ioOe       <= 4'h0;
    end else if (clkEn) begin
      if (!selected || frame_q != FR_DATA) begin
        outBit_q <= 3'd0;
        ioOe     <= 4'h0;
        ioOut    <= 4'h0;
      end else if (sckFall) begin
        ioOe <= 4'h2;
        if (outBit_q == 3'd0) begin
          ioOut      <= {2'b00, outByte[7], 1'b0};
          outShift_q <= {outByte[6:0], 1'b0};
        end else begin
          ioOut      <= {2'b00, outShift_q[7], 1'b0};
          outShift_q <= {outShift_q[6:0], 1'b0};
        end
        outBit_q <= outBit_q + 3'd1;
      end
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Read-out bytes are checked at the mux, not against the package word
  logic paramRd;
  assign paramRd = cmd_q == dword16_pkg::CMD_PARAM_RD;
  chk_enter_field: assert property (
    @(posedge core_clk) disable iff (reset)
    paramRd && addr_q == 8'h6b |-> outByte == 8'h80)
    else $error("enter field wrong");
  chk_exit_field: assert property (
    @(posedge core_clk) disable iff (reset)
    paramRd && addr_q == 8'h6a |-> outByte == 8'hc0)
    else $error("exit field wrong");
  chk_srst_field: assert property (
    @(posedge core_clk) disable iff (reset)
    paramRd && addr_q == 8'h69 |-> outByte == 8'h30)
    else $error("soft reset field wrong");
  chk_sr1_field: assert property (
    @(posedge core_clk) disable iff (reset)
    paramRd && addr_q == 8'h68 |-> outByte == 8'he8)
    else $error("sr1 field or bit 7 wrong");
  chk_reset_pair: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(resetBusy) |-> $past(rstArmed_q) && $past(cmd_q) == 8'h99)
    else $error("reset without enable pair");
  chk_reset_hold: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(resetBusy) |-> rstCnt_q == 16'(RESET_CYCLES))
    else $error("reset timer not loaded");
  chk_reject_busy: assert property (
    @(posedge core_clk) disable iff (reset)
    resetBusy && frameStart |=> frame_q == FR_SKIP)
    else $error("command taken during reset");
  chk_arm_drop: assert property (
    @(posedge core_clk) disable iff (reset)
    clkEn && cmdDone && cmd_q != 8'h66 |=> !rstArmed_q)
    else $error("reset enable not dropped");
  chk_vol_only: assert property (
    @(posedge core_clk) disable iff (reset)
    wrsrDone && wenVol_q |=> $stable(sr1NonVol))
    else $error("volatile write touched nv copy");
  chk_sr1_reload: assert property (
    @(posedge core_clk) disable iff (reset)
    clkEn && fire |=> sr1Volatile == $past(sr1NonVol))
    else $error("sr1 not reloaded");
  chk_nv_guard: assert property (
    @(posedge core_clk) disable iff (reset)
    wrsrDone && !wenNv_q |=> $stable(sr1NonVol))
    else $error("nv copy written without write enable");
  chk_vol_write: assert property (
    @(posedge core_clk) disable iff (reset)
    clkEn && wrsrDone && wenVol_q |=> sr1Volatile == $past(wrByte_q))
    else $error("volatile write lost");
  chk_busy_quiet: assert property (
    @(posedge core_clk) disable iff (reset)
    resetBusy |-> ioOe == 4'h0)
    else $error("output driven during reset");
endmodule : dword16_cmd

// ===== dword16_cmd_tb_top.sv
// Purpose: Self-checking bench for the dword 16 and soft reset block
// Assumes: Reset recovery shortened to RST_CYC cycles
// Notes:   Busy pulses are counted by a monitor, not timed by the tasks
module dword16_cmd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int RST_CYC = 40;
  logic        core_clk;
  logic        reset;
  logic        clkEn;
  logic        sck;
  logic        csN;
  logic [3:0]  ioIn;
  logic [3:0]  ioOut;
  logic [3:0]  ioOe;
  logic [1:0]  laneMode;
  logic [7:0]  sr1Volatile;
  logic [7:0]  sr1NonVol;
  logic        resetBusy;
  logic [31:0] r;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          busyRuns = 0;
  int          busyHigh = 0;
  int          oeHigh = 0;
  bit          prevBusy = 0;

  dword16_cmd #(.RESET_CYCLES(RST_CYC)) uut (
    .core_clk(core_clk), .reset(reset), .clkEn(clkEn), .sck(sck),
    .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .laneMode(laneMode), .sr1Volatile(sr1Volatile),
    .sr1NonVol(sr1NonVol), .resetBusy(resetBusy));

  spi_host_model host (.sck(sck), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
    .laneMode(laneMode));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (resetBusy === 1'b1) busyHigh++;
    if (ioOe === 4'h2) oeHigh++;
    if (resetBusy === 1'b1 && !prevBusy) busyRuns++;
    prevBusy = (resetBusy === 1'b1);
    if (cycles == 20000) begin
      n_mismatch++;
      $display("timeout at %0t", $time);
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd1(input logic [7:0] c);
    host.frame(1, {c, 32'h0}, 0, r);
  endtask : cmd1

  task automatic wrsr(input logic [7:0] c, input logic [7:0] d);
    host.frame(2, {c, d, 24'h0}, 0, r);
  endtask : wrsr

  // Pair, optionally split by a status read; counts busy pulses after
  task automatic resetPair(input bit mid, input bit expRst,
                           input logic [7:0] expVol);
    int r0;
    int h0;
    r0 = busyRuns;
    h0 = busyHigh;
    cmd1(8'h66);
    if (mid) cmd1(8'h05);
    cmd1(8'h99);
    repeat (RST_CYC + 10) @(negedge core_clk);
    chk(32'(busyRuns - r0), 32'(expRst));
    chk(32'(busyHigh - h0), expRst ? 32'(RST_CYC) : 32'h0);
    chk(32'(sr1Volatile), 32'(expVol));
  endtask : resetPair

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_param();
    logic [31:0] d;
    int          o0;
    o0 = oeHigh;
    host.frame(5, {8'h5a, 16'h0, 8'h68, 8'h00}, 4, r);
    chk(r, 32'he830c080);
    chk(32'(oeHigh != o0), 32'h1);
    chk(32'(ioOe), 32'h0);
    d = {r[7:0], r[15:8], r[23:16], r[31:24]};
    chk(32'(d[31:24]), 32'h80);
    chk(32'(d[23:14]), 32'h300);
    chk(32'({d[13:8], d[7]}), 32'h61);
    chk(32'(d[6:0]), 32'h68);
    $display("param read done");
  endtask : t_param

  task automatic t_status();
    logic [7:0] c;
    cmd1(8'h06);
    wrsr(8'h01, 8'h5c);
    chk(32'({sr1Volatile, sr1NonVol}), 32'h5c5c);
    for (int i = 0; i < 2; i++) begin
      c = i ? 8'h31 : 8'h01;
      cmd1(8'h50);
      wrsr(c, 8'h3c ^ c);
      chk(32'({sr1Volatile, sr1NonVol}), 32'({8'h3c ^ c, 8'h5c}));
    end
    host.frame(1, {8'h05, 32'h0}, 1, r);
    chk(32'(r[7:0]), 32'h0d);
    $display("status write done");
  endtask : t_status

  task automatic t_pair();
    resetPair(1'b0, 1'b1, 8'h5c);
    cmd1(8'h50);
    wrsr(8'h01, 8'h11);
    resetPair(1'b1, 1'b0, 8'h11);
    $display("reset pair done");
  endtask : t_pair

  // Enable sent while busy must be dropped, so a later reset does nothing
  task automatic t_busy();
    int r0;
    r0 = busyRuns;
    cmd1(8'h66);
    cmd1(8'h99);
    chk(32'(resetBusy), 32'h1);
    cmd1(8'h66);
    repeat (RST_CYC) @(negedge core_clk);
    cmd1(8'h99);
    repeat (10) @(negedge core_clk);
    chk(32'(busyRuns - r0), 32'h1);
    $display("busy refusal done");
  endtask : t_busy

  task automatic t_lanes();
    for (int m = 0; m < 3; m++) begin
      @(negedge core_clk) laneMode = 2'(m);
      cmd1(8'h50);
      wrsr(8'h01, 8'(8'h40 + m));
      chk(32'(sr1Volatile), 32'(8'h40 + m));
      resetPair(1'b0, 1'b1, 8'h5c);
    end
    @(negedge core_clk) laneMode = 2'd0;
    $display("lane widths done");
  endtask : t_lanes

  // Frozen clock enable: two whole frames (50h, then a status write) must pass unseen
  task automatic t_freeze();
    @(negedge core_clk) clkEn = 1'b0;
    cmd1(8'h50);
    wrsr(8'h01, 8'ha5);
    @(negedge core_clk) clkEn = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(32'(sr1Volatile), 32'h5c);
    cmd1(8'h50);
    wrsr(8'h01, 8'ha5);
    chk(32'(sr1Volatile), 32'ha5);
    $display("clock enable freeze done");
  endtask : t_freeze

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    reset    = 1'b1;
    clkEn    = 1'b1;
    laneMode = 2'd0;
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(32'({sr1Volatile, sr1NonVol, 7'h0, resetBusy}), 32'h0);
    t_param();
    t_status();
    t_pair();
    t_busy();
    t_lanes();
    t_freeze();
    final_report();
  end
endmodule : dword16_cmd_tb_top

// ===== dword16_pkg.sv
// Purpose: Constants for the parameter-dword-16 and soft reset command block
// Assumes: 40 MHz core clock
// Notes:   Used by the interpreter only; its serial front end does not use it
package dword16_pkg;
  // ---------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RST_EN   = 8'h66;
  localparam logic [7:0] CMD_RST      = 8'h99;
  localparam logic [7:0] CMD_WREN     = 8'h06;
  localparam logic [7:0] CMD_VWREN    = 8'h50;
  localparam logic [7:0] CMD_WRSR1    = 8'h01;
  localparam logic [7:0] CMD_WRSR2    = 8'h31;
  localparam logic [7:0] CMD_RDSR     = 8'h05;
  localparam logic [7:0] CMD_PARAM_RD = 8'h5a;
  // ---------------------------------------------------------------
  // Dword 16 fields
  // ---------------------------------------------------------------
  localparam logic [7:0] PARAM_BASE    = 8'h68;
  localparam int         ENTER_LSB     = 24;
  localparam logic [7:0] ENTER_FIELD   = 8'h80;
  localparam int         EXIT_LSB      = 14;
  localparam logic [9:0] EXIT_FIELD    = 10'h300;
  localparam int         SRST_LSB      = 8;
  localparam logic [5:0] SRST_FIELD    = 6'h30;
  localparam int         RFU_BIT       = 7;
  localparam logic [6:0] SR1_FIELD     = 7'h68;
  localparam logic [31:0] DWORD16 =
    {ENTER_FIELD, EXIT_FIELD, SRST_FIELD, 1'b1, SR1_FIELD};
  // ---------------------------------------------------------------
  // Status register 1 and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] SR1_NV_RESET  = 8'h00;
  localparam int         RESET_TIME_NS = 10000;
  localparam int         CLK_PERIOD_NS = 25;
  localparam int         RESET_CYCLES  = RESET_TIME_NS / CLK_PERIOD_NS;
endpackage : dword16_pkg

// ===== spi_host_model.sv
// Purpose: Host model driving the link pins in mode 0, single/dual/quad
// Assumes: Link clock period 200 ns; it stands low outside frames
// Notes:   Lanes not carrying data are toggled so stale values never pass
module spi_host_model (
  // Link pins
  output logic            sck,
  output logic            csN,
  output logic [3:0]      ioIn,
  input  wire logic [3:0] ioOut,
  // Lane width in use
  input  wire logic [1:0] laneMode
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sck  = 1'b0;
    csN  = 1'b1;
    ioIn = 4'h0;
  end

  // ---------------------------------------------------------------
  // One frame: nTx bytes out (MSB first, left aligned), nRx bytes in
  // ---------------------------------------------------------------
  // Each frame is a whole command; the host never enters continuous
  // quad read, so no mode exit is needed before a reset pair
  task automatic frame(input int nTx, input logic [39:0] tx,
                       input int nRx, output logic [31:0] rx);
    int w;
    int b;
    int k;
    logic [39:0] sh;
    w  = (laneMode == 2'd2) ? 4 : ((laneMode == 2'd1) ? 2 : 1);
    sh = tx;
    rx = '0;
    csN = 1'b0;
    for (b = 0; b < nTx * 8; b += w) begin
      sck  = 1'b0;
      ioIn = ~ioIn;
      for (k = 0; k < w; k++) begin
        ioIn[k] = sh[39 - (w - 1 - k)];
      end
      sh = sh << w;
      #100 sck = 1'b1;
      #100;
    end
    // Sample late in the high phase: output moves a few clocks after fall
    for (b = 0; b < nRx * 8; b++) begin
      sck  = 1'b0;
      ioIn = ~ioIn;
      #100 sck = 1'b1;
      #90 rx = {rx[30:0], ioOut[1]};
      #10;
    end
    sck = 1'b0;
    #100 csN = 1'b1;
    ioIn = ~ioIn;
    #300;
  endtask : frame
endmodule : spi_host_model

// ===== spi_shifter.sv
// Purpose: Serial front end: samples link pins, shifts on 1, 2 or 4 wires
// Assumes: Mode 0 or 3; input sampled on link clock rising edge
// Notes:   Output data changes on link clock falling edge
module spi_shifter (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       clkEn,
  // Link pins
  input  wire logic       sck,
  input  wire logic       csN,
  input  wire logic [3:0] ioIn,
  // Lane width: 0 single, 1 dual, 2 quad
  input  wire logic [1:0] laneMode,
  // Byte side
  output logic            byteValid,
  output logic [7:0]      byteData,
  output logic            frameStart,
  output logic            frameEnd,
  output logic            selected,
  output logic            sckFall
);
  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [5:0] syncA_q;
  logic [5:0] syncB_q;
  logic       sckOld_q;
  logic       csOld_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      // Idle pin levels, so no false link clock edge follows reset
      syncA_q  <= 6'h20;
      syncB_q  <= 6'h20;
      sckOld_q <= 1'b0;
      csOld_q  <= 1'b1;
    end else if (clkEn) begin
      syncA_q  <= {csN, ioIn, sck};
      syncB_q  <= syncA_q;
      sckOld_q <= syncB_q[0];
      csOld_q  <= syncB_q[5];
    end
  end
  logic       sckS;
  logic       csS;
  logic [3:0] ioS;
  logic       sckRise;
  assign sckS       = syncB_q[0];
  assign ioS        = syncB_q[4:1];
  assign csS        = syncB_q[5];
  assign sckRise    = clkEn && !csS && sckS && !sckOld_q;
  assign sckFall    = clkEn && !csS && !sckS && sckOld_q;
  assign frameStart = clkEn && !csS && csOld_q;
  assign frameEnd   = clkEn && csS && !csOld_q;
  assign selected   = !csS;
  // ---------------------------------------------------------------
  // Shift register
  // ---------------------------------------------------------------
  logic [7:0] shift_q;
  logic [3:0] bits_q;
  logic [7:0] shift_d;
  logic [3:0] bits_d;
  always_comb begin
    shift_d = shift_q;
    bits_d  = bits_q;
    unique case (laneMode)
      2'd1: begin
        shift_d = {shift_q[5:0], ioS[1:0]};
        bits_d  = bits_q + 4'd2;
      end
      2'd2: begin
        shift_d = {shift_q[3:0], ioS};
        bits_d  = bits_q + 4'd4;
      end
      default: begin
        shift_d = {shift_q[6:0], ioS[0]};
        bits_d  = bits_q + 4'd1;
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      shift_q   <= 8'h00;
      bits_q    <= 4'h0;
      byteValid <= 1'b0;
      byteData  <= 8'h00;
    end else if (clkEn) begin
      byteValid <= 1'b0;
      if (csS) begin
        bits_q <= 4'h0;
      end else if (sckRise) begin
        if (bits_d[3]) begin
          bits_q    <= 4'h0;
          byteValid <= 1'b1;
          byteData  <= shift_d;
        end else begin
          bits_q <= bits_d;
        end
        shift_q <= shift_d;
      end
    end
  end
endmodule : spi_shifter
